/* File: shared/pdcfg_pkg.sv */
// Purpose: Constants for the power derating configuration register bank.
// Assumes: Byte-wide registers at byte offsets; battery voltage in millivolts.
// Notes: Power caps count in 0.5 W steps; currents are in milliamps.

package pdcfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BL1_CAP = 8'h23;
  localparam logic [7:0] ADDR_BL1_MASK = 8'h24;
  localparam logic [7:0] ADDR_BL2_CAP = 8'h25;
  localparam logic [7:0] ADDR_BL2_MASK = 8'h26;
  localparam logic [7:0] ADDR_TW1_CAP = 8'h27;
  localparam logic [7:0] ADDR_TW1_MASK = 8'h28;
  localparam logic [7:0] ADDR_TW2_CAP = 8'h29;
  localparam logic [7:0] ADDR_TW2_MASK = 8'h2A;
  localparam logic [7:0] ADDR_THR_A = 8'h2B;
  localparam logic [7:0] ADDR_THR_B = 8'h2C;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CAP_45W = 8'h5A;
  localparam logic [7:0] RST_CAP_15W = 8'h1E;
  localparam logic [7:0] RST_CAP_30W = 8'h3C;
  localparam logic [7:0] RST_PDO_MASK = 8'hBE;
  localparam logic [7:0] RST_THR_A = 8'h48;
  localparam logic [7:0] RST_THR_B = 8'hA2;
  localparam logic [7:0] CAP_NONE = 8'hFF;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // Field layout of the threshold register
  // ----------------------------------------------------------------
  localparam int THR1_MSB = 7;
  localparam int THR1_LSB = 4;
  localparam logic [3:0] THR_CODE_OFF = 4'h0;
  localparam logic [3:0] THR_CODE_FIRST = 4'h1;

  // ----------------------------------------------------------------
  // Analogue scaling (millivolts, milliwatts)
  // ----------------------------------------------------------------
  localparam logic [15:0] TRIP_TOP_MV = 16'h3138;   // 12600 mV at code 1.
  localparam logic [15:0] TRIP_STEP_MV = 16'h0190;  // 400 mV per code.
  localparam logic [15:0] HYST_MV = 16'h0320;       // 800 mV.
  localparam logic [15:0] MW_PER_COUNT = 16'h01F4;  // 500 mW per count.
  localparam logic [15:0] MA_PER_A = 16'h03E8;      // 1000.
  localparam logic [15:0] CURRENT_MAX_MA = 16'hFFFF;

endpackage

/* File: core/pdcfg_trip_detect.sv */
// Purpose: Decodes the low-battery trip code and tracks the low state.
// Assumes: batt_mv_i is a settled millivolt reading synchronous to mclk_i.
// Notes: The low flag sets below the falling point, clears at or above it plus hysteresis.

`timescale 1ns/1ps

module pdcfg_trip_detect (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] code_i,
  input wire logic [15:0] batt_mv_i,
  output logic batt_low_o,
  output logic [15:0] trip_mv_o
);

  logic enabled;
  logic [3:0] steps;
  logic [19:0] drop_mv;
  logic [15:0] fall_mv;
  logic [16:0] rise_mv;
  logic next_low;

  assign enabled = (code_i != pdcfg_pkg::THR_CODE_OFF);
  assign steps = code_i - pdcfg_pkg::THR_CODE_FIRST;
  assign drop_mv = 20'(steps) * 20'(pdcfg_pkg::TRIP_STEP_MV);
  assign fall_mv = pdcfg_pkg::TRIP_TOP_MV - drop_mv[15:0];
  assign rise_mv = {1'b0, fall_mv} + {1'b0, pdcfg_pkg::HYST_MV};

  // Hysteresis keeps the cap from chattering on a noisy battery rail.
  assign next_low = !enabled ? 1'b0 :
                    (batt_mv_i < fall_mv) ? 1'b1 :
                    ({1'b0, batt_mv_i} >= rise_mv) ? 1'b0 : batt_low_o;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      batt_low_o <= 1'b0;
      trip_mv_o <= 16'h0000;
    end else begin
      batt_low_o <= next_low;
      trip_mv_o <= enabled ? fall_mv : 16'h0000;
    end
  end

endmodule

/* File: core/pdcfg_current_calc.sv */
// Purpose: Derives a PDO current from a power cap and the PDO voltage.
// Assumes: Cap counts 0.5 W; voltage in millivolts.
// Notes: A zero voltage yields zero current rather than dividing by zero.

`timescale 1ns/1ps

module pdcfg_current_calc (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] cap_i,
  input wire logic [15:0] pdo_mv_i,
  output logic [15:0] current_ma_o
);

  logic [23:0] power_mw;
  logic [33:0] scaled;
  logic [33:0] quotient;
  logic [15:0] next_ma;

  assign power_mw = 24'(cap_i) * 24'(pdcfg_pkg::MW_PER_COUNT);
  assign scaled = 34'(power_mw) * 34'(pdcfg_pkg::MA_PER_A);
  assign quotient = (pdo_mv_i == 16'h0000) ? 34'h0 : scaled / 34'(pdo_mv_i);
  assign next_ma = (quotient > 34'(pdcfg_pkg::CURRENT_MAX_MA)) ?
                   pdcfg_pkg::CURRENT_MAX_MA : quotient[15:0];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      current_ma_o <= 16'h0000;
    end else begin
      current_ma_o <= next_ma;
    end
  end

endmodule

/* File: core/pdcfg_regs.sv */
// Purpose: Power derating configuration registers and derating selection.
// Assumes: Register strobes are synchronous to mclk_i; condition inputs are levels.
// Notes: Read data appears on the edge after reg_rd_i.
//
// What this block does
// - Below battery level one, cap power at its register, 0.5 W steps, reset 45 W.
// - Below battery level two, cap power at its own register, reset 15 W.
// - Each temperature warning level caps power; resets 45 W and 30 W.
// - Each condition has an 8-bit PDO mask, reset 0xBE.
// - Enabled PDO current comes from the active condition cap, not normal rating.
// - Level one code: 0 off, 1..15 trip 12.6 V down 0.4 V, 800 mV hysteresis.

`timescale 1ns/1ps

module pdcfg_regs (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [15:0] batt_mv_i,
  input wire logic batt_low2_i,
  input wire logic temp_warn1_i,
  input wire logic temp_warn2_i,
  input wire logic [7:0] normal_power_cap_i,
  input wire logic [15:0] pdo_mv_i,
  output logic batt_low1_o,
  output logic [15:0] batt_low1_trip_mv_o,
  output logic derating_active_o,
  output logic [7:0] derated_power_cap_o,
  output logic [7:0] derated_pdo_mask_o,
  output logic [15:0] pdo_current_ma_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_sync;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] pdcfg_min(input logic [7:0] a, input logic [7:0] b);
    pdcfg_min = (a < b) ? a : b;
  endfunction

  function automatic logic [7:0] pdcfg_gate_cap(input logic act, input logic [7:0] cap);
    pdcfg_gate_cap = act ? cap : pdcfg_pkg::CAP_NONE;
  endfunction

  function automatic logic [7:0] pdcfg_gate_mask(input logic act, input logic [7:0] mask);
    pdcfg_gate_mask = act ? mask : pdcfg_pkg::MASK_ALL;
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] batt_low_level1_power_cap;
  logic [7:0] batt_low_level1_pdo_mask;
  logic [7:0] batt_low_level2_power_cap;
  logic [7:0] batt_low_level2_pdo_mask;
  logic [7:0] temp_warn1_power_cap;
  logic [7:0] temp_warn1_pdo_mask;
  logic [7:0] temp_warn2_power_cap;
  logic [7:0] temp_warn2_pdo_mask;
  logic [7:0] batt_low_threshold_a;
  logic [7:0] batt_low_threshold_b;

  wire wr_bl1_cap = reg_wr_i && (reg_addr_i == pdcfg_pkg::ADDR_BL1_CAP);
  wire wr_bl1_mask = reg_wr_i && (reg_addr_i == pdcfg_pkg::ADDR_BL1_MASK);
  wire wr_bl2_cap = reg_wr_i && (reg_addr_i == pdcfg_pkg::ADDR_BL2_CAP);
  wire wr_bl2_mask = reg_wr_i && (reg_addr_i == pdcfg_pkg::ADDR_BL2_MASK);
  wire wr_tw1_cap = reg_wr_i && (reg_addr_i == pdcfg_pkg::ADDR_TW1_CAP);
  wire wr_tw1_mask = reg_wr_i && (reg_addr_i == pdcfg_pkg::ADDR_TW1_MASK);
  wire wr_tw2_cap = reg_wr_i && (reg_addr_i == pdcfg_pkg::ADDR_TW2_CAP);
  wire wr_tw2_mask = reg_wr_i && (reg_addr_i == pdcfg_pkg::ADDR_TW2_MASK);
  wire wr_thr_a = reg_wr_i && (reg_addr_i == pdcfg_pkg::ADDR_THR_A);
  wire wr_thr_b = reg_wr_i && (reg_addr_i == pdcfg_pkg::ADDR_THR_B);

  always_ff @(posedge mclk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      batt_low_level1_power_cap <= pdcfg_pkg::RST_CAP_45W;
      batt_low_level1_pdo_mask <= pdcfg_pkg::RST_PDO_MASK;
      batt_low_level2_power_cap <= pdcfg_pkg::RST_CAP_15W;
      batt_low_level2_pdo_mask <= pdcfg_pkg::RST_PDO_MASK;
      temp_warn1_power_cap <= pdcfg_pkg::RST_CAP_45W;
      temp_warn1_pdo_mask <= pdcfg_pkg::RST_PDO_MASK;
      temp_warn2_power_cap <= pdcfg_pkg::RST_CAP_30W;
      temp_warn2_pdo_mask <= pdcfg_pkg::RST_PDO_MASK;
      batt_low_threshold_a <= pdcfg_pkg::RST_THR_A;
      batt_low_threshold_b <= pdcfg_pkg::RST_THR_B;
    end else begin
      if (wr_bl1_cap) batt_low_level1_power_cap <= reg_wdata_i;
      if (wr_bl1_mask) batt_low_level1_pdo_mask <= reg_wdata_i;
      if (wr_bl2_cap) batt_low_level2_power_cap <= reg_wdata_i;
      if (wr_bl2_mask) batt_low_level2_pdo_mask <= reg_wdata_i;
      if (wr_tw1_cap) temp_warn1_power_cap <= reg_wdata_i;
      if (wr_tw1_mask) temp_warn1_pdo_mask <= reg_wdata_i;
      if (wr_tw2_cap) temp_warn2_power_cap <= reg_wdata_i;
      if (wr_tw2_mask) temp_warn2_pdo_mask <= reg_wdata_i;
      if (wr_thr_a) batt_low_threshold_a <= reg_wdata_i;
      if (wr_thr_b) batt_low_threshold_b <= reg_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] rd_sel;

  always_comb begin
    case (reg_addr_i)
      pdcfg_pkg::ADDR_BL1_CAP: rd_sel = batt_low_level1_power_cap;
      pdcfg_pkg::ADDR_BL1_MASK: rd_sel = batt_low_level1_pdo_mask;
      pdcfg_pkg::ADDR_BL2_CAP: rd_sel = batt_low_level2_power_cap;
      pdcfg_pkg::ADDR_BL2_MASK: rd_sel = batt_low_level2_pdo_mask;
      pdcfg_pkg::ADDR_TW1_CAP: rd_sel = temp_warn1_power_cap;
      pdcfg_pkg::ADDR_TW1_MASK: rd_sel = temp_warn1_pdo_mask;
      pdcfg_pkg::ADDR_TW2_CAP: rd_sel = temp_warn2_power_cap;
      pdcfg_pkg::ADDR_TW2_MASK: rd_sel = temp_warn2_pdo_mask;
      pdcfg_pkg::ADDR_THR_A: rd_sel = batt_low_threshold_a;
      pdcfg_pkg::ADDR_THR_B: rd_sel = batt_low_threshold_b;
      default: rd_sel = pdcfg_pkg::RDATA_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      reg_rdata_o <= pdcfg_pkg::RDATA_UNMAPPED;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_sel;
    end
  end

  // ----------------------------------------------------------------
  // Level one low-battery detection
  // ----------------------------------------------------------------
  wire [3:0] thr1_code = batt_low_threshold_a[pdcfg_pkg::THR1_MSB:pdcfg_pkg::THR1_LSB];

  pdcfg_trip_detect u_trip (
    .mclk_i(mclk_i),
    .rst_n_i(rst_sync),
    .code_i(thr1_code),
    .batt_mv_i(batt_mv_i),
    .batt_low_o(batt_low1_o),
    .trip_mv_o(batt_low1_trip_mv_o)
  );

  // ----------------------------------------------------------------
  // Derating selection
  // ----------------------------------------------------------------
  // Inactive conditions contribute the neutral cap and mask, so the
  // minimum and the intersection only see the active ones.
  wire [7:0] cap_bl1 = pdcfg_gate_cap(batt_low1_o, batt_low_level1_power_cap);
  wire [7:0] cap_bl2 = pdcfg_gate_cap(batt_low2_i, batt_low_level2_power_cap);
  wire [7:0] cap_tw1 = pdcfg_gate_cap(temp_warn1_i, temp_warn1_power_cap);
  wire [7:0] cap_tw2 = pdcfg_gate_cap(temp_warn2_i, temp_warn2_power_cap);
  wire [7:0] mask_bl1 = pdcfg_gate_mask(batt_low1_o, batt_low_level1_pdo_mask);
  wire [7:0] mask_bl2 = pdcfg_gate_mask(batt_low2_i, batt_low_level2_pdo_mask);
  wire [7:0] mask_tw1 = pdcfg_gate_mask(temp_warn1_i, temp_warn1_pdo_mask);
  wire [7:0] mask_tw2 = pdcfg_gate_mask(temp_warn2_i, temp_warn2_pdo_mask);

  wire any_active = batt_low1_o || batt_low2_i || temp_warn1_i || temp_warn2_i;
  wire [7:0] min_cap = pdcfg_min(pdcfg_min(cap_bl1, cap_bl2), pdcfg_min(cap_tw1, cap_tw2));
  wire [7:0] all_mask = mask_bl1 & mask_bl2 & mask_tw1 & mask_tw2;
  wire [7:0] next_cap = any_active ? min_cap : normal_power_cap_i;
  wire [7:0] next_mask = any_active ? all_mask : pdcfg_pkg::MASK_ALL;

  always_ff @(posedge mclk_i or negedge rst_sync) begin
    if (!rst_sync) begin
      derating_active_o <= 1'b0;
      derated_power_cap_o <= pdcfg_pkg::CAP_NONE;
      derated_pdo_mask_o <= pdcfg_pkg::MASK_ALL;
    end else begin
      derating_active_o <= any_active;
      derated_power_cap_o <= next_cap;
      derated_pdo_mask_o <= next_mask;
    end
  end

  // ----------------------------------------------------------------
  // Offered current
  // ----------------------------------------------------------------
  // The registered cap feeds the divider so its long path starts at a flop.
  pdcfg_current_calc u_curr (
    .mclk_i(mclk_i),
    .rst_n_i(rst_sync),
    .cap_i(derated_power_cap_o),
    .pdo_mv_i(pdo_mv_i),
    .current_ma_o(pdo_current_ma_o)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_bl1_cap_applied: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    batt_low1_o && !batt_low2_i && !temp_warn1_i && !temp_warn2_i
    |=> derated_power_cap_o == $past(batt_low_level1_power_cap))
    else $error("Level one battery cap not applied.");

  a_bl1_write_lands: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    reg_wr_i && reg_addr_i == pdcfg_pkg::ADDR_BL1_CAP
    |=> batt_low_level1_power_cap == $past(reg_wdata_i))
    else $error("Level one cap write not stored.");

  a_bl2_cap_bound: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    batt_low2_i |=> derated_power_cap_o <= $past(batt_low_level2_power_cap))
    else $error("Level two battery cap exceeded.");

  a_tw_cap_bound: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    temp_warn1_i || temp_warn2_i |=> derating_active_o &&
    derated_power_cap_o <= $past(temp_warn1_i ? temp_warn1_power_cap
                                              : temp_warn2_power_cap))
    else $error("Temperature warning cap exceeded.");

  a_mask_subset: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    temp_warn2_i |=> (derated_pdo_mask_o & ~$past(temp_warn2_pdo_mask)) == 8'h00)
    else $error("Mask keeps a PDO the warning removed.");

  a_bl2_mask_bound: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    batt_low2_i
    |=> (derated_pdo_mask_o & ~$past(batt_low_level2_pdo_mask)) == 8'h00)
    else $error("Mask keeps a PDO level two removed.");

  a_tw1_mask_bound: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    temp_warn1_i
    |=> (derated_pdo_mask_o & ~$past(temp_warn1_pdo_mask)) == 8'h00)
    else $error("Mask keeps a PDO warning one removed.");

  a_mask_readback: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    reg_rd_i && reg_addr_i == pdcfg_pkg::ADDR_TW2_MASK
    |=> reg_rdata_o == $past(temp_warn2_pdo_mask))
    else $error("Mask register read back wrong.");

  a_rdata_holds: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("Read data changed without a read.");

  a_current_follows: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    derated_power_cap_o == 8'h00 ##1 $stable(derated_power_cap_o)
    |-> pdo_current_ma_o == 16'h0000)
    else $error("Current not derived from the cap.");

  a_zero_volt_current: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    pdo_mv_i == 16'h0000 |=> pdo_current_ma_o == 16'h0000)
    else $error("Current not zero at zero volts.");

  a_normal_cap: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    !any_active |=> derated_power_cap_o == $past(normal_power_cap_i))
    else $error("Normal rating not in force.");

  a_trip_disabled: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    thr1_code == pdcfg_pkg::THR_CODE_OFF |=> !batt_low1_o)
    else $error("Detection active with code zero.");

  a_trip_zero_off: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    thr1_code == pdcfg_pkg::THR_CODE_OFF |=> batt_low1_trip_mv_o == 16'h0000)
    else $error("Trip point shown with code zero.");

  a_trip_sets: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    thr1_code == pdcfg_pkg::THR_CODE_FIRST && batt_mv_i < pdcfg_pkg::TRIP_TOP_MV |=> batt_low1_o)
    else $error("Level one did not trip below 12.6 V.");

  a_trip_hold: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    batt_low1_o && thr1_code == pdcfg_pkg::THR_CODE_FIRST
    && batt_mv_i < pdcfg_pkg::TRIP_TOP_MV + pdcfg_pkg::HYST_MV |=> batt_low1_o)
    else $error("Level one released inside hysteresis.");

  a_min_of_two: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    temp_warn1_i && temp_warn2_i |=> derated_power_cap_o ==
    pdcfg_min($past(cap_bl1), pdcfg_min($past(cap_bl2),
      pdcfg_min($past(temp_warn1_power_cap), $past(temp_warn2_power_cap)))))
    else $error("Smallest active cap not chosen.");

  a_idle_normal: assert property (@(posedge mclk_i) disable iff (!rst_sync)
    !any_active |=> !derating_active_o && derated_pdo_mask_o == 8'hFF)
    else $error("Derating shown with no condition.");

  c_bl1_trip: cover property (@(posedge mclk_i) disable iff (!rst_sync)
    !batt_low1_o ##1 batt_low1_o);
  c_two_active: cover property (@(posedge mclk_i) disable iff (!rst_sync)
    temp_warn1_i && batt_low2_i);
  c_cap_write: cover property (@(posedge mclk_i) disable iff (!rst_sync)
    wr_bl1_cap ##1 batt_low1_o);
  c_all_four: cover property (@(posedge mclk_i) disable iff (!rst_sync)
    batt_low1_o && batt_low2_i && temp_warn1_i && temp_warn2_i);
  c_zero_cap: cover property (@(posedge mclk_i) disable iff (!rst_sync)
    derated_power_cap_o == 8'h00);

endmodule

/* File: sim/pdcfg_regs_test.sv */
// Purpose: Self-checking bench for the power derating register bank.
// Assumes: Strobes are driven 1 ns after the rising edge and held for one cycle.
// Notes: The bench drives every port itself; expectations come from the package constants and the row table's write values.

`timescale 1ns/1ps

module pdcfg_regs_test;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] rst;
    logic [7:0] wval;
  } pdcfg_row_t;

  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic [15:0] batt_mv_i = 16'h36B0;
  logic batt_low2_i = 1'b0;
  logic temp_warn1_i = 1'b0;
  logic temp_warn2_i = 1'b0;
  logic [7:0] normal_power_cap_i = 8'h70;
  logic [15:0] pdo_mv_i = 16'h4E20;
  logic batt_low1_o;
  logic [15:0] batt_low1_trip_mv_o;
  logic derating_active_o;
  logic [7:0] derated_power_cap_o;
  logic [7:0] derated_pdo_mask_o;
  logic [15:0] pdo_current_ma_o;
  int errors = 0;
  int samples_checked = 0;
  logic [7:0] rdat;
  logic [7:0] ecap;
  logic [7:0] emask;
  logic [15:0] etrip;

  // Write values keep the level-one code at 0100 so the trip point stays put.
  pdcfg_row_t rows [10] = '{
    '{pdcfg_pkg::ADDR_BL1_CAP, pdcfg_pkg::RST_CAP_45W, 8'h60},
    '{pdcfg_pkg::ADDR_BL1_MASK, pdcfg_pkg::RST_PDO_MASK, 8'hFE},
    '{pdcfg_pkg::ADDR_BL2_CAP, pdcfg_pkg::RST_CAP_15W, 8'h20},
    '{pdcfg_pkg::ADDR_BL2_MASK, pdcfg_pkg::RST_PDO_MASK, 8'h7F},
    '{pdcfg_pkg::ADDR_TW1_CAP, pdcfg_pkg::RST_CAP_45W, 8'h40},
    '{pdcfg_pkg::ADDR_TW1_MASK, pdcfg_pkg::RST_PDO_MASK, 8'hBD},
    '{pdcfg_pkg::ADDR_TW2_CAP, pdcfg_pkg::RST_CAP_30W, 8'h50},
    '{pdcfg_pkg::ADDR_TW2_MASK, pdcfg_pkg::RST_PDO_MASK, 8'hE7},
    '{pdcfg_pkg::ADDR_THR_A, pdcfg_pkg::RST_THR_A, 8'h4C},
    '{pdcfg_pkg::ADDR_THR_B, pdcfg_pkg::RST_THR_B, 8'h5A}
  };

  pdcfg_regs pdcfg_regs_inst (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .batt_mv_i(batt_mv_i),
    .batt_low2_i(batt_low2_i),
    .temp_warn1_i(temp_warn1_i),
    .temp_warn2_i(temp_warn2_i),
    .normal_power_cap_i(normal_power_cap_i),
    .pdo_mv_i(pdo_mv_i),
    .batt_low1_o(batt_low1_o),
    .batt_low1_trip_mv_o(batt_low1_trip_mv_o),
    .derating_active_o(derating_active_o),
    .derated_power_cap_o(derated_power_cap_o),
    .derated_pdo_mask_o(derated_pdo_mask_o),
    .pdo_current_ma_o(pdo_current_ma_o)
  );

  always #4 mclk_i = ~mclk_i;

  // ----------------------------------------------------------------
  // Bus tasks and comparisons
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_wr_i = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    #1;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge mclk_i);
    #1;
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask

  task automatic settle();
    repeat (4) @(posedge mclk_i);
    #1;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Saturating current for a cap in 0.5 W counts at a voltage in millivolts.
  function automatic logic [15:0] exp_current(input logic [7:0] cap, input logic [15:0] mv);
    logic [31:0] p;
    if (mv == 16'h0000) begin
      return 16'h0000;
    end
    p = (32'(cap) * 32'(pdcfg_pkg::MW_PER_COUNT) * 32'(pdcfg_pkg::MA_PER_A)) / 32'(mv);
    return (p > 32'h0000_FFFF) ? 16'hFFFF : p[15:0];
  endfunction

  task automatic finish_test();
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge mclk_i);
    #1;
    rst_n_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    for (int i = 0; i < 10; i++) begin
      rd(rows[i].addr, rdat);
      check_byte("reset value", rows[i].rst, rdat);
      wr(rows[i].addr, rows[i].wval);
      rd(rows[i].addr, rdat);
      check_byte("readback", rows[i].wval, rdat);
    end
    wr(8'h30, 8'h55);
    rd(8'h30, rdat);
    check_byte("unmapped read", pdcfg_pkg::RDATA_UNMAPPED, rdat);
    // Every combination of the four conditions, caps and masks all distinct.
    for (int c = 0; c < 16; c++) begin
      batt_mv_i = c[0] ? 16'h2710 : 16'h36B0;
      batt_low2_i = c[1];
      temp_warn1_i = c[2];
      temp_warn2_i = c[3];
      settle();
      ecap = (c == 0) ? normal_power_cap_i : pdcfg_pkg::CAP_NONE;
      emask = pdcfg_pkg::MASK_ALL;
      for (int k = 0; k < 4; k++) begin
        if (c[k] && rows[2 * k].wval < ecap) ecap = rows[2 * k].wval;
        if (c[k]) emask = emask & rows[2 * k + 1].wval;
      end
      check_bit("level one low", c[0], batt_low1_o);
      check_bit("derating active", c != 0, derating_active_o);
      check_byte("power cap", ecap, derated_power_cap_o);
      check_byte("pdo mask", emask, derated_pdo_mask_o);
      check_word("pdo current", exp_current(ecap, pdo_mv_i), pdo_current_ma_o);
    end
    // Trip code decode across the whole field.
    batt_mv_i = 16'h36B0;
    for (int code = 0; code < 16; code++) begin
      wr(pdcfg_pkg::ADDR_THR_A, {4'(code), 4'h8});
      settle();
      etrip = (code == 0) ? 16'h0000 :
        16'(pdcfg_pkg::TRIP_TOP_MV - (code - 1) * pdcfg_pkg::TRIP_STEP_MV);
      check_word("trip point", etrip, batt_low1_trip_mv_o);
    end
    // Hysteresis band at code 0001, the highest trip point.
    wr(pdcfg_pkg::ADDR_THR_A, 8'h18);
    etrip = pdcfg_pkg::TRIP_TOP_MV;
    batt_mv_i = etrip;
    settle();
    check_bit("at trip point", 1'b0, batt_low1_o);
    batt_mv_i = etrip - 16'h0001;
    settle();
    check_bit("below trip point", 1'b1, batt_low1_o);
    batt_mv_i = etrip + pdcfg_pkg::HYST_MV - 16'h0001;
    settle();
    check_bit("inside hysteresis", 1'b1, batt_low1_o);
    batt_mv_i = etrip + pdcfg_pkg::HYST_MV;
    settle();
    check_bit("above hysteresis", 1'b0, batt_low1_o);
    wr(pdcfg_pkg::ADDR_THR_A, 8'h08);
    batt_mv_i = 16'h0000;
    settle();
    check_bit("detection off", 1'b0, batt_low1_o);
    // Normal rating in force, saturating and zero-voltage currents.
    batt_mv_i = 16'h36B0;
    batt_low2_i = 1'b0;
    temp_warn1_i = 1'b0;
    temp_warn2_i = 1'b0;
    normal_power_cap_i = 8'hFF;
    pdo_mv_i = 16'h03E8;
    settle();
    check_word("saturated current", 16'hFFFF, pdo_current_ma_o);
    pdo_mv_i = 16'h0000;
    settle();
    check_word("zero voltage current", 16'h0000, pdo_current_ma_o);
    pdo_mv_i = 16'h4E20;
    normal_power_cap_i = 8'h00;
    settle();
    check_word("zero cap current", exp_current(8'h00, pdo_mv_i), pdo_current_ma_o);
    // Reset in mid-run with a condition active.
    temp_warn1_i = 1'b1;
    settle();
    rst_n_i = 1'b0;
    @(posedge mclk_i);
    #1;
    check_byte("cap in reset", pdcfg_pkg::CAP_NONE, derated_power_cap_o);
    check_bit("active in reset", 1'b0, derating_active_o);
    rst_n_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(pdcfg_pkg::ADDR_TW1_CAP, rdat);
    check_byte("cap reset again", pdcfg_pkg::RST_CAP_45W, rdat);
    settle();
    check_byte("cap after reset", pdcfg_pkg::RST_CAP_45W, derated_power_cap_o);
    check_word("current after reset", exp_current(pdcfg_pkg::RST_CAP_45W, pdo_mv_i),
      pdo_current_ma_o);
    finish_test();
  end

  initial begin
    #100000;
    errors++;
    finish_test();
  end
endmodule
